// [ldrr_route.sv]
// logical device base decode and interrupt and dma routing
`timescale 1ns/1ns
`default_nettype none
`include "ldrr_cfg.svh"
module ldrr_route
    import ldrr_pkg::*;
#(
    parameter int NDEV = 4,
    parameter int NIRQ = 16,
    parameter int NDMA = 4
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // configuration port
    input wire logic cfg_state,
    input wire logic cfg_strobe,
    input wire ldrr_cfg_acc_t cfg_acc,
    output logic [7:0] cfg_rdata,
    // host address decode
    input wire logic [15:0] host_addr,
    output logic [NDEV-1:0] dev_select,
    output logic [2:0] dev_offset,
    output logic ecp_ext_select,
    output logic [1:0] ecp_ext_reg,
    output logic kbd_data_select,
    output logic kbd_cmd_select,
    output logic pp_epp_allowed,
    // device side enables and requests
    input wire ldrr_dev_en_t dev_en,
    input wire logic serial_irq_mode,
    input wire logic [NDEV-1:0] dev_irq,
    input wire logic [NDEV-1:0] dev_drq,
    input wire logic smi_event,
    // isa side routing pins
    output logic [NIRQ-1:0] irq_out,
    output logic [NIRQ-1:0] irq_oe,
    output logic [NDMA-1:0] dma_request_pins,
    output logic [NDMA-1:0] drq_oe,
    output logic [NDEV-1:0] dev_dack_en,
    output logic system_mgmt_int_n
);
    // ------------------------------------------------------------
    // configuration storage
    // ------------------------------------------------------------
    logic [NDEV-1:0] activate;
    logic [7:0] base_address_high [NDEV];
    logic [7:0] base_address_low [NDEV];
    logic [7:0] interrupt_level_select [NDEV];
    logic [7:0] dma_channel_select [NDEV];
    logic [11:0] base [NDEV];
    logic [NDEV-1:0] base_ok;
    logic [NDEV-1:0] irq_go;
    logic [NDEV-1:0] drq_go;
    logic [NIRQ-1:0] next_irq_out;
    logic [NIRQ-1:0] next_irq_oe;
    logic [NDMA-1:0] next_drq;
    logic [NDMA-1:0] next_drq_oe;
    logic cfg_hit;
    logic [NDEV-1:0] dev_live;

    // level usable on the pins in the present irq mode
    // levels 14 and 15 have no pin behind them and are never driven
    function automatic logic lvl_ok(input logic [3:0] lvl, input logic ser);
        lvl_ok = 1'b0;
        if (lvl != 4'h0 && lvl <= 4'hD) begin
            if (ser) begin
                lvl_ok = 1'b1;
            end else begin
                lvl_ok = (lvl >= 4'h3 && lvl <= 4'h7) || (lvl >= 4'hA && lvl <= 4'hC);
            end
        end
    endfunction

    // dma codes that name a real channel
    function automatic logic chan_ok(input logic [2:0] code);
        chan_ok = code != 3'h0 && code <= 3'h3;
    endfunction

    // only accesses in the configuration state reach the registers
    assign cfg_hit = cfg_state && cfg_strobe && (cfg_acc.dev < 3'(NDEV));

    // one write decode per index, shared by the five configuration registers below
    function automatic logic wr_to(input logic hit, input ldrr_cfg_acc_t acc,
                                   input logic [7:0] idx);
        wr_to = hit && acc.wr && acc.index == idx;
    endfunction

    // activate bit per device; clearing it frees the device's routing
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            activate <= '0;
        end else if (wr_to(cfg_hit, cfg_acc, `LDRR_IDX_ACTIVATE)) begin
            activate[cfg_acc.dev[1:0]] <= cfg_acc.data[0];
        end
    end

    // base high byte; only its low nibble reaches the decode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NDEV; i++) begin
                base_address_high[i] <= `LDRR_BASE_RST;
            end
        end else if (wr_to(cfg_hit, cfg_acc, `LDRR_IDX_BASE_HI)) begin
            base_address_high[cfg_acc.dev[1:0]] <= cfg_acc.data;
        end
    end

    // base low byte
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NDEV; i++) begin
                base_address_low[i] <= `LDRR_BASE_RST;
            end
        end else if (wr_to(cfg_hit, cfg_acc, `LDRR_IDX_BASE_LO)) begin
            base_address_low[cfg_acc.dev[1:0]] <= cfg_acc.data;
        end
    end

    // interrupt level select, all eight bits kept for read back
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NDEV; i++) begin
                interrupt_level_select[i] <= `LDRR_IRQ_SEL_RST;
            end
        end else if (wr_to(cfg_hit, cfg_acc, `LDRR_IDX_IRQ_SEL)) begin
            interrupt_level_select[cfg_acc.dev[1:0]] <= cfg_acc.data;
        end
    end

    // dma channel select; resets to the inactive code so nothing is claimed
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NDEV; i++) begin
                dma_channel_select[i] <= `LDRR_DMA_SEL_RST;
            end
        end else if (wr_to(cfg_hit, cfg_acc, `LDRR_IDX_DMA_SEL)) begin
            dma_channel_select[cfg_acc.dev[1:0]] <= cfg_acc.data;
        end
    end

    // read data is registered; unimplemented indices read zero
    // a read has no side effect, so a repeated read is harmless
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_rdata <= 8'h00;
        end else if (cfg_hit && !cfg_acc.wr) begin
            case (cfg_acc.index)
                `LDRR_IDX_ACTIVATE: cfg_rdata <= {7'h00, activate[cfg_acc.dev[1:0]]};
                `LDRR_IDX_BASE_HI: cfg_rdata <= base_address_high[cfg_acc.dev[1:0]];
                `LDRR_IDX_BASE_LO: cfg_rdata <= base_address_low[cfg_acc.dev[1:0]];
                `LDRR_IDX_IRQ_SEL: cfg_rdata <= interrupt_level_select[cfg_acc.dev[1:0]];
                `LDRR_IDX_DMA_SEL: cfg_rdata <= dma_channel_select[cfg_acc.dev[1:0]];
                default: cfg_rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // base validity per device
    // ------------------------------------------------------------
    // only twelve bits of base matter, the upper nibble is ignored
    generate
        for (genvar d = 0; d < NDEV; d++) begin : g_base
            assign base[d] = {base_address_high[d][3:0], base_address_low[d]};
            if (d == 1) begin : g_pp
                // parallel port may sit on a 4-byte step
                assign base_ok[d] = base[d] >= `LDRR_BASE_MIN
                    && base[d] <= `LDRR_BASE_MAX4 && base[d][1:0] == 2'b00;
            end else begin : g_other
                assign base_ok[d] = base[d] >= `LDRR_BASE_MIN
                    && base[d] <= `LDRR_BASE_MAX8 && base[d][2:0] == 3'b000;
            end
        end
    endgenerate

    // a device takes part only while active and at a valid base
    assign dev_live = activate & base_ok;

    // ------------------------------------------------------------
    // host address decode
    // ------------------------------------------------------------
    // inactive devices and invalid bases never claim a cycle
    always_comb begin
        dev_select = '0;
        dev_offset = host_addr[2:0];
        for (int d = 0; d < NDEV; d++) begin
            if (dev_live[d]) begin
                if (d == 1 && base[d][2] == 1'b1) begin
                    // 4-byte base: only data, status and control exist
                    dev_select[d] = host_addr[11:2] == base[d][11:2];
                end else begin
                    dev_select[d] = host_addr[11:3] == base[d][11:3];
                end
            end
        end
    end

    // EPP is offered only when bit 2 of the parallel base is clear
    assign pp_epp_allowed = base[1][2] == 1'b0;

    // extended ECP registers above the parallel base
    // offsets wrap within twelve bits, as the host decode does
    always_comb begin
        ecp_ext_select = 1'b0;
        ecp_ext_reg = 2'b00;
        if (dev_live[1]) begin
            if (host_addr[11:0] == 12'(base[1] + `LDRR_ECP_OFS_A)) begin
                ecp_ext_select = 1'b1;
                ecp_ext_reg = 2'b00;
            end else if (host_addr[11:0] == 12'(base[1] + `LDRR_ECP_OFS_B)) begin
                ecp_ext_select = 1'b1;
                ecp_ext_reg = 2'b01;
            end else if (host_addr[11:0] == 12'(base[1] + `LDRR_ECP_OFS_X)) begin
                ecp_ext_select = 1'b1;
                ecp_ext_reg = 2'b10;
            end
        end
    end

    // keyboard unit does not move
    // the relocation registers have no effect on these two decodes
    assign kbd_data_select = host_addr[11:0] == `LDRR_KBD_DATA;
    assign kbd_cmd_select = host_addr[11:0] == `LDRR_KBD_CMD;

    // ------------------------------------------------------------
    // per-device irq and dma enables
    // ------------------------------------------------------------
    always_comb begin
        irq_go = '0;
        drq_go = '0;
        // floppy: output register enable and power both required
        irq_go[0] = dev_en.fdc_dor_floppy_dma_int_enable && dev_en.fdc_powered;
        drq_go[0] = dev_en.fdc_dor_floppy_dma_int_enable && dev_en.fdc_powered;
        // parallel: mode table decides who controls the irq pin
        if (dev_en.pp_ecp_mode) begin
            case (dev_en.pp_ecr_mode)
                3'b010, 3'b011, 3'b110: irq_go[1] = !dev_en.pp_ecr_svc;
                default: irq_go[1] = dev_en.pp_parallel_int_enable && !dev_en.pp_ecr_svc;
            endcase
            drq_go[1] = dev_en.pp_ecr_floppy_dma_int_enable;
        end else begin
            irq_go[1] = dev_en.pp_parallel_int_enable;
            drq_go[1] = 1'b0;
        end
        // serial: any of four enables plus aux output two
        irq_go[2] = |dev_en.sp_ier_low[3:0] && dev_en.sp_aux_output_two[0];
        irq_go[3] = |dev_en.sp_ier_low[7:4] && dev_en.sp_aux_output_two[1];
        drq_go[3] = dev_en.sp2_floppy_dma_int_enable;
    end

    // ------------------------------------------------------------
    // routing onto the pins
    // ------------------------------------------------------------
    // several devices on one line are or-ed; lines nobody owns float
    always_comb begin
        next_irq_out = '0;
        next_irq_oe = '0;
        for (int d = 0; d < NDEV; d++) begin
            if (dev_live[d] && irq_go[d]
                && lvl_ok(interrupt_level_select[d][3:0], serial_irq_mode)) begin
                next_irq_oe[interrupt_level_select[d][3:0]] = 1'b1;
                if (dev_irq[d]) begin
                    next_irq_out[interrupt_level_select[d][3:0]] = 1'b1;
                end
            end
        end
    end

    // dma lines follow the same pattern; codes 0 and 4..7 claim nothing
    always_comb begin
        next_drq = '0;
        next_drq_oe = '0;
        dev_dack_en = '0;
        for (int d = 0; d < NDEV; d++) begin
            if (dev_live[d] && drq_go[d]
                && chan_ok(dma_channel_select[d][2:0])) begin
                next_drq_oe[dma_channel_select[d][1:0]] = 1'b1;
                dev_dack_en[d] = 1'b1;
                if (dev_drq[d]) begin
                    next_drq[dma_channel_select[d][1:0]] = 1'b1;
                end
            end
        end
    end

    // irq pins are registered so that decode glitches never reach the bus
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_out <= '0;
            irq_oe <= '0;
        end else begin
            irq_out <= next_irq_out;
            irq_oe <= next_irq_oe;
        end
    end

    // dma pins registered for the same reason, at the cost of one cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            dma_request_pins <= '0;
            drq_oe <= '0;
        end else begin
            dma_request_pins <= next_drq;
            drq_oe <= next_drq_oe;
        end
    end

    // management interrupt shares IRQ2; software keeps them apart
    // no stretching: a one-cycle event gives a one-cycle low pulse
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            system_mgmt_int_n <= 1'b1;
        end else begin
            system_mgmt_int_n <= !smi_event;
        end
    end
endmodule
`default_nettype wire

// [ldrr_cfg.svh]
// constants for the logical device resource routing block
`ifndef LDRR_CFG_SVH
`define LDRR_CFG_SVH
// ------------------------------------------------------------
// configuration indices
// ------------------------------------------------------------
`define LDRR_IDX_ACTIVATE 8'h30
`define LDRR_IDX_BASE_HI 8'h60
`define LDRR_IDX_BASE_LO 8'h61
`define LDRR_IDX_IRQ_SEL 8'h70
`define LDRR_IDX_DMA_SEL 8'h74
// ------------------------------------------------------------
// reset values and ranges
// ------------------------------------------------------------
`define LDRR_IRQ_SEL_RST 8'h00
`define LDRR_DMA_SEL_RST 8'h04
`define LDRR_BASE_RST 8'h00
`define LDRR_BASE_MIN 12'h100
`define LDRR_BASE_MAX8 12'hFF8
`define LDRR_BASE_MAX4 12'hFFC
// ------------------------------------------------------------
// fixed offsets and fixed keyboard addresses
// ------------------------------------------------------------
`define LDRR_ECP_OFS_A 12'h400
`define LDRR_ECP_OFS_B 12'h401
`define LDRR_ECP_OFS_X 12'h402
`define LDRR_KBD_DATA 12'h060
`define LDRR_KBD_CMD 12'h064
// ------------------------------------------------------------
// device bit positions
// ------------------------------------------------------------
`define LDRR_FDC_FLOPPY_DMA_INT_ENABLE_BIT 3
`define LDRR_PP_PARALLEL_INT_ENABLE_BIT 4
`define LDRR_ECR_SVC_BIT 2
`define LDRR_ECR_FLOPPY_DMA_INT_ENABLE_BIT 3
`define LDRR_MCR_AUX_OUTPUT_TWO_BIT 3
`endif

// [ldrr_pkg.sv]
// types for the logical device resource routing block
package ldrr_pkg;
    // logical device slots of this block
    typedef enum logic [2:0] {
        LDRR_DEV_FDC = 3'h0,
        LDRR_DEV_PP = 3'h1,
        LDRR_DEV_SP1 = 3'h2,
        LDRR_DEV_SP2 = 3'h3,
        LDRR_DEV_NONE = 3'h4
    } ldrr_dev_t;
    // one configuration access from the index/data port
    typedef struct packed {
        logic wr;
        logic [2:0] dev;
        logic [7:0] index;
        logic [7:0] data;
    } ldrr_cfg_acc_t;
    // per-device enable bits from inside the logical devices
    typedef struct packed {
        logic fdc_dor_floppy_dma_int_enable;
        logic fdc_powered;
        logic pp_parallel_int_enable;
        logic pp_ecp_mode;
        logic [2:0] pp_ecr_mode;
        logic pp_ecr_svc;
        logic pp_ecr_floppy_dma_int_enable;
        logic [1:0] sp_aux_output_two;
        logic [7:0] sp_ier_low;
        logic sp2_floppy_dma_int_enable;
    } ldrr_dev_en_t;
endpackage

// [ldrr_route_chk.sv]
// assertion checker for the resource routing block
`timescale 1ns/1ns
`default_nettype none
module ldrr_route_chk
    import ldrr_pkg::*;
#(
    parameter int NDEV = 4,
    parameter int NIRQ = 16,
    parameter int NDMA = 4
) (
    // clock, reset and driven inputs
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic cfg_state,
    input wire logic cfg_strobe,
    input wire ldrr_cfg_acc_t cfg_acc,
    input wire logic [15:0] host_addr,
    input wire ldrr_dev_en_t dev_en,
    input wire logic serial_irq_mode,
    input wire logic smi_event,
    // outputs under watch
    input wire logic [7:0] cfg_rdata,
    input wire logic [2:0] dev_offset,
    input wire logic kbd_data_select,
    input wire logic kbd_cmd_select,
    input wire logic [NIRQ-1:0] irq_oe,
    input wire logic [NDMA-1:0] dma_request_pins,
    input wire logic [NDMA-1:0] drq_oe,
    input wire logic [NDEV-1:0] dev_dack_en,
    input wire logic system_mgmt_int_n
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // a read that the port takes, and a cycle with no read taken
    sequence cfg_rd_s;
        cfg_state && cfg_strobe && !cfg_acc.wr && cfg_acc.dev < 3'h4;
    endsequence
    sequence no_rd_s;
        $past(nrst) && !$past(cfg_state && cfg_strobe && !cfg_acc.wr);
    endsequence
    rd_hold_a: assert property (no_rd_s |-> $stable(cfg_rdata))
        else $error("read data moved without a read");
    smi_level_a: assert property ($past(nrst) |-> system_mgmt_int_n == !$past(smi_event))
        else $error("management interrupt not active low");
    kbd_fixed_a: assert property (kbd_data_select == (host_addr[11:0] == 12'h060)
        && kbd_cmd_select == (host_addr[11:0] == 12'h064)) else $error("keyboard decode wrong");
    dev_offset_a: assert property (dev_offset == host_addr[2:0])
        else $error("register offset wrong");
    no_level_a: assert property ((irq_oe & 16'hC001) == 16'h0000)
        else $error("irq driven on a level no field can name");
    par_mode_a: assert property ($past(!serial_irq_mode) |-> (irq_oe & 16'h2306) == 16'h0000)
        else $error("irq level unavailable in parallel mode driven");
    irq_idle_a: assert property ($past(!dev_en.fdc_dor_floppy_dma_int_enable && !dev_en.pp_parallel_int_enable
        && !dev_en.pp_ecp_mode && dev_en.sp_aux_output_two == 2'b00) |-> irq_oe == '0)
        else $error("irq driven with every device disabled");
    drq_idle_a: assert property ($past(!dev_en.fdc_dor_floppy_dma_int_enable && !dev_en.pp_ecr_floppy_dma_int_enable
        && !dev_en.sp2_floppy_dma_int_enable) |-> drq_oe == '0) else $error("dma driven with none enabled");
    chan_zero_a: assert property (!drq_oe[0] && !dma_request_pins[0])
        else $error("reserved dma channel driven");
    fdc_ack_a: assert property (dev_dack_en[0] |-> dev_en.fdc_dor_floppy_dma_int_enable && dev_en.fdc_powered)
        else $error("floppy ack enabled while disabled");
    ecp_ack_a: assert property (dev_dack_en[1] |-> dev_en.pp_ecp_mode && dev_en.pp_ecr_floppy_dma_int_enable)
        else $error("parallel ack enabled outside ecp dma");
    rd_seen_c: cover property (cfg_rd_s);
endmodule
bind ldrr_route ldrr_route_chk #(.NDEV(NDEV), .NIRQ(NIRQ), .NDMA(NDMA)) i_chk (.sys_clk, .nrst,
    .cfg_state, .cfg_strobe, .cfg_acc, .host_addr, .dev_en, .serial_irq_mode, .smi_event,
    .cfg_rdata, .dev_offset, .kbd_data_select, .kbd_cmd_select, .irq_oe, .dma_request_pins,
    .drq_oe, .dev_dack_en, .system_mgmt_int_n);
`default_nettype wire

// [ldrr_host_model.sv]
// host side interrupt and dma controller model
`timescale 1ns/1ns
`default_nettype none
module ldrr_host_model (
    // clock
    input wire logic sys_clk,
    // routing pins of the device
    input wire logic [15:0] irq_out,
    input wire logic [15:0] irq_oe,
    input wire logic [3:0] dma_request_pins,
    input wire logic [3:0] drq_oe,
    // resolved wires and edge count
    output logic [15:0] irq_line,
    output logic [3:0] drq_line,
    output int irq_edges
);
    logic [15:0] prev_line = 16'hFFFF;
    // board pull-up on released irq lines, pull-down on released dma lines
    assign irq_line = (irq_out & irq_oe) | ~irq_oe;
    assign drq_line = dma_request_pins & drq_oe;
    // the controller latches rising edges only, so a level held high counts once
    initial irq_edges = 0;
    always @(posedge sys_clk) begin
        irq_edges <= irq_edges + $countones(irq_line & ~prev_line & irq_oe);
        prev_line <= irq_line;
    end
endmodule
`default_nettype wire

// [tb.sv]
// self-checking testbench for the resource routing block
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ldrr_pkg::*;
    logic sys_clk = 0, nrst = 0, cfg_state = 0, cfg_strobe = 0, serial_irq_mode = 0;
    logic smi_event = 0, ecp_ext_select, kbd_data_select, kbd_cmd_select, pp_epp_allowed;
    logic system_mgmt_int_n;
    ldrr_cfg_acc_t cfg_acc = '0;
    ldrr_dev_en_t dev_en = '0;
    logic [15:0] host_addr = '0, irq_out, irq_oe, irq_line;
    logic [3:0] dev_irq = '0, dev_drq = '0, dev_select, drq_oe, dma_request_pins, dev_dack_en;
    logic [3:0] drq_line;
    logic [7:0] cfg_rdata;
    logic [2:0] dev_offset;
    logic [1:0] ecp_ext_reg;
    int fail_count = 0, checks = 0, irq_edges;
    always #4 sys_clk = ~sys_clk;
    ldrr_route i_ldrr_route (.sys_clk, .nrst, .cfg_state, .cfg_strobe, .cfg_acc, .cfg_rdata,
        .host_addr, .dev_select, .dev_offset, .ecp_ext_select, .ecp_ext_reg, .kbd_data_select,
        .kbd_cmd_select, .pp_epp_allowed, .dev_en, .serial_irq_mode, .dev_irq, .dev_drq,
        .smi_event, .irq_out, .irq_oe, .dma_request_pins, .drq_oe, .dev_dack_en,
        .system_mgmt_int_n);
    ldrr_host_model i_ldrr_host_model (.sys_clk, .irq_out, .irq_oe, .dma_request_pins,
        .drq_oe, .irq_line, .drq_line, .irq_edges);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ends on a rising edge, so the next drive lands on it; reads see pre-edge values
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one strobe; read data is sampled a full cycle after the taking edge
    task automatic cfg(input logic wr, input logic [2:0] dev, input logic [7:0] idx,
                       input logic [7:0] dat);
        @(posedge sys_clk);
        cfg_strobe <= 1'b1;
        cfg_acc <= '{wr, dev, idx, dat};
        @(posedge sys_clk);
        cfg_strobe <= 1'b0;
        step(1);
    endtask
    function automatic logic [15:0] exp_irq(input logic [3:0] lvl, input logic smode);
        exp_irq = 16'h0000;
        if (lvl >= 4'h1 && lvl <= 4'hD && (smode || lvl inside {[4'h3:4'h7], [4'hA:4'hC]}))
            exp_irq[lvl] = 1'b1;
    endfunction
    function automatic logic hit(input logic [11:0] base, input logic [15:0] a);
        hit = base >= 12'h100 && base <= 12'hFF8 && a[11:3] == base[11:3];
    endfunction
    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a hang is cut at some sixty times the expected run
    initial begin
        #200000;
        fail_count++;
        finish_test();
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        ldrr_dev_en_t v;
        logic [15:0] a;
        logic [3:0] lvl;
        int e0;
        void'($urandom(32'h4AFDC2C9));
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        cfg_state <= 1'b1;
        for (int d = 0; d < 4; d++) begin
            cfg(1'b0, 3'(d), 8'h74, 8'h00);
            chk("dma_sel", 16'h0004, {8'h00, cfg_rdata});
        end
        // writes outside the configuration state must not land
        cfg_state <= 1'b0;
        cfg(1'b1, 3'h0, 8'h70, 8'h06);
        cfg_state <= 1'b1;
        cfg(1'b0, 3'h0, 8'h70, 8'h00);
        chk("irq_sel", 16'h0000, {8'h00, cfg_rdata});
        cfg(1'b1, 3'h0, 8'h30, 8'h01);
        cfg(1'b1, 3'h0, 8'h60, 8'h03);
        cfg(1'b1, 3'h0, 8'h61, 8'hF0);
        cfg(1'b1, 3'h0, 8'h70, 8'h06);
        cfg(1'b1, 3'h0, 8'h74, 8'h02);
        // random addresses, two on the keyboard ports, eleven near the floppy base, high bits always random
        for (int i = 0; i < 24; i++) begin
            a = 16'($urandom);
            if (i < 2) a[11:0] = i ? 12'h064 : 12'h060;
            else if (i[0]) a[11:3] = 9'h07E;
            host_addr <= a;
            step(1);
            chk("fdc_select", {15'h0, hit(12'h3F0, a)}, {15'h0, dev_select[0]});
            chk("kbd_data", 16'(a[11:0] == 12'h060), 16'(kbd_data_select));
            chk("kbd_cmd", 16'(a[11:0] == 12'h064), 16'(kbd_cmd_select));
        end
        dev_en <= '{fdc_dor_floppy_dma_int_enable: 1'b1, fdc_powered: 1'b1, default: '0};
        dev_irq <= 4'h1;
        dev_drq <= 4'h1;
        serial_irq_mode <= 1'b1;
        step(3);
        chk("fdc_irq_oe", 16'h0040, irq_oe);
        chk("fdc_drq_oe", 16'h0004, {12'h0, drq_oe});
        chk("fdc_dack", 16'h0001, {12'h0, dev_dack_en});
        chk("fdc_drq_line", 16'h0004, {12'h0, drq_line});
        e0 = irq_edges;
        repeat (3) begin
            dev_irq <= 4'h0;
            step(2);
            dev_irq <= 4'h1;
            step(2);
        end
        step(1); // the host model counts the last rise one edge later
        chk("irq_edges", 16'h0003, 16'(irq_edges - e0));
        dev_en <= '{fdc_powered: 1'b1, default: '0};
        step(3);
        chk("fdc_off_irq", 16'h0000, irq_oe);
        chk("fdc_off_line", 16'hFFFF, irq_line);
        chk("fdc_off_dack", 16'h0000, {12'h0, dev_dack_en});
        cfg(1'b1, 3'h0, 8'h60, 8'h00);
        cfg(1'b1, 3'h0, 8'h61, 8'hF8);
        host_addr <= 16'h00F8;
        step(1);
        chk("low_base", 16'h0000, {15'h0, dev_select[0]});
        // parallel port: ecp offsets, epp on 4-byte base
        cfg(1'b1, 3'h1, 8'h30, 8'h01);
        cfg(1'b1, 3'h1, 8'h60, 8'h03);
        cfg(1'b1, 3'h1, 8'h61, 8'h78);
        for (int k = 0; k < 3; k++) begin
            host_addr <= 16'h0778 + 16'(k);
            step(1);
            chk("ecp_reg", {14'h1, 2'(k)}, {13'h0, ecp_ext_select, ecp_ext_reg});
        end
        chk("epp_8", 16'h0001, {15'h0, pp_epp_allowed});
        cfg(1'b1, 3'h1, 8'h61, 8'h7C);
        host_addr <= 16'h037C;
        step(1);
        chk("epp_4", 16'h0002, {14'h0, dev_select[1], pp_epp_allowed});
        dev_en <= '{pp_parallel_int_enable: 1'b1, default: '0};
        dev_irq <= 4'h2;
        for (int i = 0; i < 24; i++) begin
            lvl = (i < 3) ? ((i == 2) ? 4'h2 : 4'hD + 4'(i)) : 4'($urandom_range(15, 0));
            smi_event <= (lvl == 4'h2) ? 1'b0 : 1'($urandom);
            serial_irq_mode <= (i < 3) || 1'($urandom);
            cfg(1'b1, 3'h1, 8'h70, {4'h0, lvl});
            step(2);
            chk("pp_level", exp_irq(lvl, serial_irq_mode), irq_oe);
            chk("smi_n", 16'(!smi_event), 16'(system_mgmt_int_n));
        end
        smi_event <= 1'b0;
        cfg(1'b1, 3'h1, 8'h70, 8'h05);
        cfg(1'b1, 3'h1, 8'h74, 8'h01);
        dev_drq <= 4'h2;
        for (int m = 0; m < 9; m++) begin
            v = '{pp_ecp_mode: 1'b1, pp_ecr_mode: 3'(m), pp_ecr_svc: m == 8, default: '0};
            v.pp_ecr_floppy_dma_int_enable = 1'b1;
            dev_en <= v;
            step(3);
            chk("ecp_irq", (m inside {2, 3, 6}) ? 16'h0020 : 16'h0000, irq_oe);
            chk("ecp_drq", 16'h0002, {12'h0, drq_oe});
        end
        dev_en <= '{pp_ecr_floppy_dma_int_enable: 1'b1, default: '0};
        step(3);
        chk("spp_irq_drq", 16'h0000, irq_oe | {12'h0, drq_oe});
        // serial port 1: any enable bit plus aux output two
        cfg(1'b1, 3'h2, 8'h30, 8'h01);
        cfg(1'b1, 3'h2, 8'h60, 8'h02);
        cfg(1'b1, 3'h2, 8'h61, 8'hF8);
        cfg(1'b1, 3'h2, 8'h70, 8'h04);
        dev_irq <= 4'h4;
        for (int j = 0; j < 32; j++) begin
            v = '{sp_aux_output_two: {1'b0, j[4]}, sp_ier_low: {4'h0, 4'(j)}, default: '0};
            dev_en <= v;
            step(3);
            chk("sp_irq", (j[4] && j[3:0] != 0) ? 16'h0010 : 16'h0000, irq_oe);
        end
        // serial port 2: dma on channel 3 through its own enable bit
        cfg(1'b1, 3'h3, 8'h30, 8'h01);
        cfg(1'b1, 3'h3, 8'h60, 8'h02);
        cfg(1'b1, 3'h3, 8'h61, 8'hE8);
        cfg(1'b1, 3'h3, 8'h74, 8'h03);
        dev_en <= '{sp2_floppy_dma_int_enable: 1'b1, default: '0};
        dev_drq <= 4'h8;
        step(3);
        chk("sp2_drq_oe", 16'h0008, {12'h0, drq_oe});
        chk("sp2_drq_line", 16'h0008, {12'h0, drq_line});
        chk("sp2_dack", 16'h0008, {12'h0, dev_dack_en});
        finish_test();
    end
endmodule
`default_nettype wire
